// ===== core/vpt_port.v
// per-port trunk conditioning, loopback, pattern, rate and test logic
// Operation
// - on carrier group alarm, condition port idle or busy per selection
// - active call held two seconds, dropped, then busy until alarm ends
// - alarm clear returns port to idle automatically
// - loopback selection is off, digital or analog
// - pattern goes only to selected port; none disables generation
// - milliwatt mode sends 1 kHz reference tone, receive adjust added to its level
// - quiet pattern terminates line, sends no analog signal
// - default rate is 64K with no compression resource
// - rate changes refused when no compression resource card installed
// - compressed pairs sum to 64K: 24/40, 32/32, 40/24
// - suffix 1 maps to odd half, suffix 2 to even half
// - resource reads n/a at 64K; otherwise one of three positions
// - monitor alarms when any signaling bit toggles over 255 in four seconds
// - transition monitor powers up off, flips on each toggle command
// - test status n/a for inactive port or WAN, else off or on
// - transmit and receive signaling bits exposed for monitoring only
// - bus-connect systems never override receive signaling bits
// - tone injection only in cross-connect systems
// - injection choices pcm, 300Hz, 1kHz, 3kHz, quiet; pcm default
// - hybrid balance loads three-byte pattern; only first set active
// - user pass-through forwards network pcm unchanged
// - distinct trunk-conditioning status while alarm conditions port
`include "vpt_defines.vh"
module vpt_port #(
    parameter HOLD_CYCLES   = (`VPT_CLK_HZ / 1000) * `VPT_HOLD_MS,
    parameter WINDOW_CYCLES = (`VPT_CLK_HZ / 1000) * `VPT_WINDOW_MS
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        port_active_i,
    input  wire        wan_active_i,
    input  wire        carrier_group_alarm_i,
    input  wire        alarm_conditioning_select_i,
    input  wire        call_active_i,
    input  wire        test_mode_i,
    input  wire        cross_connect_i,
    input  wire        port_selected_i,
    input  wire [1:0]  loopback_select_i,
    input  wire [1:0]  test_pattern_select_i,
    input  wire [4:0]  receive_level_adjust_i,
    input  wire [2:0]  balance_set_i,
    input  wire        resource_installed_i,
    input  wire        rate_write_i,
    input  wire [2:0]  rate_i,
    input  wire [1:0]  resource_position_i,
    input  wire        monitor_toggle_i,
    input  wire [3:0]  transmit_signaling_bits_i,
    input  wire [3:0]  receive_signaling_bits_i,
    input  wire [2:0]  user_side_injection_i,
    input  wire [2:0]  network_side_injection_i,
    input  wire [7:0]  pcm_from_network_i,
    input  wire [7:0]  pcm_from_user_i,
    output reg  [7:0]  pcm_user_side_injection_o,
    output reg  [7:0]  pcm_to_network_o,
    output reg  [2:0]  port_status_o,
    output reg         drop_call_o,
    output reg         present_busy_o,
    output reg  [1:0]  loopback_o,
    output reg         line_terminate_o,
    output reg  [23:0] balance_pattern_o,
    output reg  [2:0]  rate_o,
    output reg         pair_even_o,
    output reg  [1:0]  resource_o,
    output reg  [1:0]  test_status_o,
    output reg         monitor_on_o,
    output reg         sig_alarm_o,
    output reg  [3:0]  transmit_signaling_bits_o,
    output reg  [3:0]  receive_signaling_bits_o
);
    localparam S_IDLE = 4'b0001;
    localparam S_HOLD = 4'b0010;
    localparam S_BUSY = 4'b0100;
    localparam S_IDLE_TC = 4'b1000;

    // a 1 kHz sine is crudely approximated by a square wave toggled every TONE_HALF clocks
    localparam TONE_HALF = `VPT_CLK_HZ / (2 * `VPT_TONE_HZ);
    localparam T300_HALF = `VPT_CLK_HZ / 600;
    localparam T3K_HALF  = `VPT_CLK_HZ / 6000;

    reg [3:0]  state_reg;
    reg [3:0]  state_next;
    reg [31:0] hold_reg;
    reg [31:0] window_reg;
    reg [31:0] tone_cnt_reg;
    reg        tone1k_reg;
    reg [31:0] t300_reg;
    reg        t300_ph_reg;
    reg [31:0] t3k_reg;
    reg        t3k_ph_reg;
    reg        boundary_reg;
    reg [3:0]  sig_a_reg;
    reg [3:0]  sig_b_reg;
    reg [3:0]  sig_c_reg;
    reg [3:0]  rsig_a_reg;
    reg [3:0]  rsig_b_reg;
    reg [3:0]  rsig_c_reg;
    reg        alarm_a_reg;
    reg        alarm_b_reg;
    reg        alarm_c_reg;
    wire [7:0] overrun;
    wire       alarm = alarm_b_reg & alarm_c_reg;
    wire       alarm_clr = ~alarm_b_reg & ~alarm_c_reg;
    wire       in_use = port_active_i & wan_active_i;

    function [7:0] tone_sample;
        input       phase;
        input [4:0] level;
        reg   [7:0] magnitude;
        begin
            // level is added to the reference amplitude, mu-law style sign bit
            magnitude   = ((`VPT_PCM_MW_LEVEL >> 1) & 8'h7F) + {3'h0, level};
            tone_sample = {phase, magnitude[6:0]};
        end
    endfunction

    function [7:0] inject;
        input [2:0] sel;
        input [7:0] pass;
        begin
            case (sel)
                `VPT_INJ_300HZ: inject = tone_sample(t300_ph_reg, 5'h00);
                `VPT_INJ_1KHZ:  inject = tone_sample(tone1k_reg, 5'h00);
                `VPT_INJ_3KHZ:  inject = tone_sample(t3k_ph_reg, 5'h00);
                `VPT_INJ_QUIET: inject = `VPT_PCM_QUIET;
                default:        inject = pass;
            endcase
        end
    endfunction

    function rate_valid;
        input [2:0] r;
        begin
            rate_valid = (r <= `VPT_RATE_40K_2);
        end
    endfunction

    // alarm is a pin from the wan side: three-flop filter
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alarm_a_reg <= 1'b0;
            alarm_b_reg <= 1'b0;
            alarm_c_reg <= 1'b0;
            sig_a_reg   <= 4'h0;
            sig_b_reg   <= 4'h0;
            sig_c_reg   <= 4'h0;
            rsig_a_reg  <= 4'h0;
            rsig_b_reg  <= 4'h0;
            rsig_c_reg  <= 4'h0;
        end else begin
            alarm_a_reg <= carrier_group_alarm_i;
            alarm_b_reg <= alarm_a_reg;
            alarm_c_reg <= alarm_b_reg;
            sig_a_reg   <= transmit_signaling_bits_i;
            sig_b_reg   <= sig_a_reg;
            sig_c_reg   <= sig_b_reg;
            rsig_a_reg  <= receive_signaling_bits_i;
            rsig_b_reg  <= rsig_a_reg;
            rsig_c_reg  <= rsig_b_reg;
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (alarm && call_active_i)
                    state_next = S_HOLD;
                else if (alarm && alarm_conditioning_select_i)
                    state_next = S_BUSY;
                else if (alarm)
                    state_next = S_IDLE_TC;
            end
            S_HOLD: begin
                if (alarm_clr)
                    state_next = S_IDLE;
                else if (hold_reg == HOLD_CYCLES - 1)
                    state_next = S_BUSY;
            end
            S_BUSY: if (alarm_clr) state_next = S_IDLE;
            S_IDLE_TC: if (alarm_clr) state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= S_IDLE;
            hold_reg  <= 32'h0;
        end else begin
            state_reg <= state_next;
            hold_reg  <= (state_reg == S_HOLD) ? hold_reg + 32'h1 : 32'h0;
        end
    end

    // free-running tone and interval timers
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_cnt_reg <= 32'h0;
            tone1k_reg   <= 1'b0;
            t300_reg     <= 32'h0;
            t300_ph_reg  <= 1'b0;
            t3k_reg      <= 32'h0;
            t3k_ph_reg   <= 1'b0;
            window_reg   <= 32'h0;
            boundary_reg <= 1'b0;
        end else begin
            tone_cnt_reg <= (tone_cnt_reg == TONE_HALF - 1) ? 32'h0 : tone_cnt_reg + 32'h1;
            if (tone_cnt_reg == TONE_HALF - 1)
                tone1k_reg <= ~tone1k_reg;
            t300_reg <= (t300_reg == T300_HALF - 1) ? 32'h0 : t300_reg + 32'h1;
            if (t300_reg == T300_HALF - 1)
                t300_ph_reg <= ~t300_ph_reg;
            t3k_reg <= (t3k_reg == T3K_HALF - 1) ? 32'h0 : t3k_reg + 32'h1;
            if (t3k_reg == T3K_HALF - 1)
                t3k_ph_reg <= ~t3k_ph_reg;
            window_reg   <= (window_reg == WINDOW_CYCLES - 1) ? 32'h0 : window_reg + 32'h1;
            boundary_reg <= (window_reg == WINDOW_CYCLES - 1);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sig
            vpt_sig_counter u_tx (
                .clock_i    (clock_i),
                .rst_n_i    (rst_n_i),
                .bit_i      (sig_c_reg[g]),
                .enable_i   (monitor_on_o & in_use),
                .boundary_i (boundary_reg),
                .overrun_o  (overrun[g])
            );
            vpt_sig_counter u_rx (
                .clock_i    (clock_i),
                .rst_n_i    (rst_n_i),
                .bit_i      (rsig_c_reg[g]),
                .enable_i   (monitor_on_o & in_use),
                .boundary_i (boundary_reg),
                .overrun_o  (overrun[g + 4])
            );
        end
    endgenerate

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcm_user_side_injection_o             <= `VPT_PCM_QUIET;
            pcm_to_network_o          <= `VPT_PCM_QUIET;
            port_status_o             <= `VPT_ST_IDLE;
            drop_call_o               <= 1'b0;
            present_busy_o            <= 1'b0;
            loopback_o                <= `VPT_LB_OFF;
            line_terminate_o          <= 1'b0;
            balance_pattern_o         <= `VPT_BAL_FIRST_BALANCE_SET;
            rate_o                    <= `VPT_RATE_64K;
            pair_even_o               <= 1'b0;
            resource_o                <= `VPT_RES_NA;
            test_status_o             <= `VPT_TEST_NA;
            monitor_on_o              <= 1'b0;
            sig_alarm_o               <= 1'b0;
            transmit_signaling_bits_o <= 4'h0;
            receive_signaling_bits_o  <= 4'h0;
        end else begin
            if (monitor_toggle_i)
                monitor_on_o <= ~monitor_on_o;
            // sticky until the monitor is turned off
            if (!monitor_on_o)
                sig_alarm_o <= 1'b0;
            else if (|overrun)
                sig_alarm_o <= 1'b1;
            // monitor only: inputs are echoed, no override path exists
            transmit_signaling_bits_o <= sig_c_reg;
            receive_signaling_bits_o  <= rsig_c_reg;
            drop_call_o    <= (state_next == S_BUSY) && (state_reg == S_HOLD);
            present_busy_o <= (state_reg == S_BUSY);
            if (!port_active_i)
                port_status_o <= `VPT_ST_IDLE;
            else if (state_reg != S_IDLE)
                port_status_o <= `VPT_ST_TC;
            else
                port_status_o <= call_active_i ? `VPT_ST_CALL : `VPT_ST_IDLE;
            if (loopback_select_i <= `VPT_LB_ANALOG)
                loopback_o <= loopback_select_i;
            line_terminate_o <= port_selected_i &&
                                (test_pattern_select_i == `VPT_PAT_QUIET);
            // only the first set is active; reserved sets keep it
            balance_pattern_o <= `VPT_BAL_FIRST_BALANCE_SET;
            if (rate_write_i && resource_installed_i && rate_valid(rate_i)) begin
                rate_o      <= rate_i;
                pair_even_o <= (rate_i >= `VPT_RATE_24K_2);
            end
            if (rate_o == `VPT_RATE_64K)
                resource_o <= `VPT_RES_NA;
            else if (resource_position_i != `VPT_RES_NA)
                resource_o <= resource_position_i;
            if (!in_use)
                test_status_o <= `VPT_TEST_NA;
            else
                test_status_o <= test_mode_i ? `VPT_TEST_ON : `VPT_TEST_OFF;
            // user direction: pattern first, then injection, else pass-through
            if (port_selected_i && test_pattern_select_i == `VPT_PAT_MILLIWATT)
                pcm_user_side_injection_o <= tone_sample(tone1k_reg, receive_level_adjust_i);
            else if (port_selected_i && test_pattern_select_i == `VPT_PAT_QUIET)
                pcm_user_side_injection_o <= `VPT_PCM_QUIET;
            else if (cross_connect_i)
                pcm_user_side_injection_o <= inject(user_side_injection_i, pcm_from_network_i);
            else
                pcm_user_side_injection_o <= pcm_from_network_i;
            if (cross_connect_i)
                pcm_to_network_o <= inject(network_side_injection_i, pcm_from_user_i);
            else
                pcm_to_network_o <= pcm_from_user_i;
        end
    end
endmodule // vpt_port

// ===== inc/vpt_defines.vh
// constants for the voice port test and conditioning block
`ifndef VPT_DEFINES_VH
`define VPT_DEFINES_VH
`define VPT_CLK_HZ          50000000
`define VPT_HOLD_MS         2000
`define VPT_WINDOW_MS       4000
`define VPT_TONE_HZ         1000
`define VPT_TRANS_LIMIT     8'hFF
`define VPT_LB_OFF          2'h0
`define VPT_LB_DIGITAL      2'h1
`define VPT_LB_ANALOG       2'h2
`define VPT_PAT_NONE        2'h0
`define VPT_PAT_MILLIWATT   2'h1
`define VPT_PAT_QUIET       2'h2
`define VPT_INJ_PCM         3'h0
`define VPT_INJ_300HZ       3'h1
`define VPT_INJ_1KHZ        3'h2
`define VPT_INJ_3KHZ        3'h3
`define VPT_INJ_QUIET       3'h4
`define VPT_RATE_64K        3'h0
`define VPT_RATE_24K_1      3'h1
`define VPT_RATE_32K_1      3'h2
`define VPT_RATE_40K_1      3'h3
`define VPT_RATE_24K_2      3'h4
`define VPT_RATE_32K_2      3'h5
`define VPT_RATE_40K_2      3'h6
`define VPT_RES_NA          2'h0
`define VPT_RES_LAST        2'h3
`define VPT_TEST_NA         2'h0
`define VPT_TEST_OFF        2'h1
`define VPT_TEST_ON         2'h2
`define VPT_ST_IDLE         3'h0
`define VPT_ST_CALL         3'h1
`define VPT_ST_HOLD         3'h2
`define VPT_ST_BUSY         3'h3
`define VPT_ST_TC           3'h4
`define VPT_BAL_FIRST_BALANCE_SET        24'h000000
`define VPT_PCM_QUIET       8'hFF
`define VPT_PCM_MW_LEVEL    8'h7F
`endif

// ===== core/vpt_sig_counter.v
// transition counter for one signaling bit over the monitoring interval
`include "vpt_defines.vh"
module vpt_sig_counter (
    input  wire clock_i,
    input  wire rst_n_i,
    input  wire bit_i,
    input  wire enable_i,
    input  wire boundary_i,
    output reg  overrun_o
);
    reg       last_reg;
    reg [7:0] count_reg;
    wire      toggle = bit_i ^ last_reg;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_reg  <= 1'b0;
            count_reg <= 8'h00;
            overrun_o <= 1'b0;
        end else begin
            last_reg <= bit_i;
            if (!enable_i || boundary_i) begin
                count_reg <= 8'h00;
                overrun_o <= 1'b0;
            end else if (toggle) begin
                // saturate: the 256th toggle is the one that exceeds the limit
                if (count_reg == `VPT_TRANS_LIMIT)
                    overrun_o <= 1'b1;
                else
                    count_reg <= count_reg + 8'h01;
            end
        end
    end
endmodule // vpt_sig_counter

// ===== test/vpt_port_props.sv
// concurrent checks on the voice port block outputs
`include "vpt_defines.vh"
module vpt_port_props (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire        port_active_i,
    input wire        wan_active_i,
    input wire        carrier_group_alarm_i,
    input wire        resource_installed_i,
    input wire [3:0]  receive_signaling_bits_i,
    input wire        drop_call_o,
    input wire        present_busy_o,
    input wire [2:0]  port_status_o,
    input wire [23:0] balance_pattern_o,
    input wire [2:0]  rate_o,
    input wire        pair_even_o,
    input wire [1:0]  resource_o,
    input wire [1:0]  test_status_o,
    input wire        monitor_on_o,
    input wire        sig_alarm_o,
    input wire [3:0]  receive_signaling_bits_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // filter and state update take five edges, eight leaves margin
    reg [3:0] calm_reg;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            calm_reg <= 4'h0;
        else if (carrier_group_alarm_i)
            calm_reg <= 4'h0;
        else if (calm_reg != 4'hF)
            calm_reg <= calm_reg + 4'h1;
    end
    a_drop_one_cycle: assert property (drop_call_o |=> !drop_call_o)
        else $error("drop pulse too long");
    a_busy_after_drop: assert property (
        drop_call_o && carrier_group_alarm_i |-> ##[0:2] present_busy_o)
        else $error("no busy after drop");
    a_clear_gives_idle: assert property (
        calm_reg >= 4'h8 |-> !present_busy_o && port_status_o != `VPT_ST_TC)
        else $error("port still conditioned after clear");
    a_balance_first_set: assert property (balance_pattern_o == `VPT_BAL_FIRST_BALANCE_SET)
        else $error("balance pattern not first set");
    a_rate_refused: assert property (!resource_installed_i [*3] |-> $stable(rate_o))
        else $error("rate changed without resource card");
    a_resource_not_used: assert property (
        rate_o == `VPT_RATE_64K && $past(rate_o) == `VPT_RATE_64K |-> resource_o == `VPT_RES_NA)
        else $error("resource shown at full rate");
    a_pair_half_map: assert property (
        $stable(rate_o) && rate_o != `VPT_RATE_64K |-> pair_even_o == (rate_o >= `VPT_RATE_24K_2))
        else $error("wrong pair half");
    a_test_status_na: assert property (
        (!port_active_i || !wan_active_i) [*3] |-> test_status_o == `VPT_TEST_NA)
        else $error("test status not n/a");
    a_alarm_needs_monitor: assert property (!monitor_on_o [*3] |-> !sig_alarm_o)
        else $error("signaling alarm with monitor off");
    a_rx_bits_mirror: assert property (
        $stable(receive_signaling_bits_i) [*5] |-> receive_signaling_bits_o == receive_signaling_bits_i)
        else $error("receive bits not mirrored");
endmodule // vpt_port_props

bind vpt_port vpt_port_props vpt_port_props_i (.clock_i, .rst_n_i, .port_active_i, .wan_active_i,
    .carrier_group_alarm_i, .resource_installed_i, .receive_signaling_bits_i, .drop_call_o,
    .present_busy_o, .port_status_o, .balance_pattern_o, .rate_o, .pair_even_o, .resource_o,
    .test_status_o, .monitor_on_o, .sig_alarm_o, .receive_signaling_bits_o);

// ===== test/vpt_far_end.sv
// far end model: network pcm word and receive signaling bursts
module vpt_far_end (
    input  wire       clock_i,
    input  wire       rst_n_i,
    input  wire       start_i,
    input  wire [9:0] burst_i,
    input  wire [7:0] word_i,
    output reg  [7:0] pcm_o,
    output reg  [3:0] abcd_o,
    output wire       busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [9:0] left_reg;
    assign busy_o = left_reg != 10'h000;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_reg <= 10'h000;
            abcd_o   <= 4'h5;
            pcm_o    <= 8'h00;
        end else begin
            pcm_o <= word_i;
            if (start_i)
                left_reg <= burst_i;
            else if (busy_o) begin
                // one toggle per cycle, the fastest the far end can signal
                left_reg  <= left_reg - 10'h001;
                abcd_o[0] <= ~abcd_o[0];
            end
        end
    end
endmodule // vpt_far_end

// ===== test/vpt_port_tb.sv
// self-checking bench for the voice port block
`include "vpt_defines.vh"
module vpt_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, rst_n_i = 1'b0, port_active_i = 1'b1, wan_active_i = 1'b1;
    logic carrier_group_alarm_i = 1'b0, alarm_conditioning_select_i = 1'b0, call_active_i = 1'b0;
    logic test_mode_i = 1'b0, cross_connect_i = 1'b1, port_selected_i = 1'b1, start = 1'b0;
    logic resource_installed_i = 1'b0, rate_write_i = 1'b0, monitor_toggle_i = 1'b0, far_busy;
    logic [1:0] loopback_select_i = 2'h0, test_pattern_select_i = 2'h0, resource_position_i = 2'h0;
    logic [2:0] rate_i = 3'h0, user_side_injection_i = 3'h0, network_side_injection_i = 3'h0;
    logic [3:0] transmit_signaling_bits_i = 4'h0, receive_signaling_bits_i;
    logic [7:0] pcm_from_user_i = 8'hC3, word = 8'h5A, pcm_from_network_i;
    logic [9:0] burst = 10'h000;
    logic [2:0] balance_set_i = 3'h0;
    logic [4:0] receive_level_adjust_i = 5'h00;
    wire  [7:0] pcm_user_side_injection_o, pcm_to_network_o;
    wire  [2:0] port_status_o, rate_o;
    wire  [1:0] loopback_o, resource_o, test_status_o;
    wire  [23:0] balance_pattern_o;
    wire  [3:0] transmit_signaling_bits_o, receive_signaling_bits_o;
    wire  drop_call_o, present_busy_o, line_terminate_o, pair_even_o, monitor_on_o, sig_alarm_o;
    int   miscompares = 0, samples_checked = 0, cycles = 0;
    // short counts keep the run small; expectations below follow them
    vpt_port #(.HOLD_CYCLES(20), .WINDOW_CYCLES(600)) vpt_port_i (
        .clock_i, .rst_n_i, .port_active_i, .wan_active_i, .carrier_group_alarm_i,
        .alarm_conditioning_select_i, .call_active_i, .test_mode_i, .cross_connect_i,
        .port_selected_i, .loopback_select_i, .test_pattern_select_i,
        .receive_level_adjust_i, .balance_set_i, .resource_installed_i,
        .rate_write_i, .rate_i, .resource_position_i, .monitor_toggle_i,
        .transmit_signaling_bits_i, .receive_signaling_bits_i, .user_side_injection_i,
        .network_side_injection_i, .pcm_from_network_i, .pcm_from_user_i, .pcm_user_side_injection_o,
        .pcm_to_network_o, .port_status_o, .drop_call_o, .present_busy_o, .loopback_o,
        .line_terminate_o, .balance_pattern_o, .rate_o, .pair_even_o, .resource_o,
        .test_status_o, .monitor_on_o, .sig_alarm_o, .transmit_signaling_bits_o,
        .receive_signaling_bits_o);
    vpt_far_end vpt_far_end_i (.clock_i, .rst_n_i, .start_i(start), .burst_i(burst),
        .word_i(word), .pcm_o(pcm_from_network_i), .abcd_o(receive_signaling_bits_i),
        .busy_o(far_busy));
    task chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task tally_and_finish;
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_status;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i) {test_mode_i, wan_active_i, port_active_i} <= i[2:0];
            cyc(4);
            chk(test_status_o, !(i[0] && i[1]) ? `VPT_TEST_NA :
                i[2] ? `VPT_TEST_ON : `VPT_TEST_OFF);
        end
        @(posedge clock_i) transmit_signaling_bits_i <= 4'hA;
        cyc(6);
        chk(transmit_signaling_bits_o, 4'hA);
    endtask
    task t_cga_busy;
        int n;
        for (int s = 0; s < 2; s++) begin
            @(posedge clock_i) {alarm_conditioning_select_i, carrier_group_alarm_i} <= {s[0], 1'b1};
            for (n = 0; n < 12 && port_status_o !== `VPT_ST_TC; n++) @(negedge clock_i);
            cyc(2);
            chk(port_status_o, `VPT_ST_TC);
            chk(present_busy_o, s[0]);
            @(posedge clock_i) carrier_group_alarm_i <= 1'b0;
            for (n = 0; n < 12 && port_status_o !== `VPT_ST_IDLE; n++) @(negedge clock_i);
            chk(port_status_o, `VPT_ST_IDLE);
            chk(present_busy_o, 1'b0);
        end
    endtask
    task t_cga_call;
        int n;
        @(posedge clock_i) call_active_i <= 1'b1;
        cyc(3);
        chk(port_status_o, `VPT_ST_CALL);
        @(posedge clock_i) carrier_group_alarm_i <= 1'b1;
        for (n = 0; n < 40 && drop_call_o !== 1'b1; n++) @(negedge clock_i);
        chk(n >= 20 && n <= 28, 1'b1);
        cyc(3);
        chk(present_busy_o, 1'b1);
        @(posedge clock_i) {carrier_group_alarm_i, call_active_i} <= 2'h0;
        cyc(10);
        chk(present_busy_o, 1'b0);
    endtask
    task t_rate(input logic inst, input logic [2:0] r, input logic [2:0] er);
        @(posedge clock_i) {resource_installed_i, rate_i, rate_write_i} <= {inst, r, 1'b1};
        @(posedge clock_i) rate_write_i <= 1'b0;
        cyc(3);
        chk(rate_o, er);
        if (er != `VPT_RATE_64K) chk(pair_even_o, er >= `VPT_RATE_24K_2);
        chk(resource_o, er == `VPT_RATE_64K ? `VPT_RES_NA : 2'h2);
    endtask
    task t_rates;
        @(posedge clock_i) resource_position_i <= 2'h2;
        t_rate(1'b0, `VPT_RATE_32K_1, `VPT_RATE_64K);
        for (int r = 1; r < 7; r++) t_rate(1'b1, r[2:0], r[2:0]);
        t_rate(1'b1, 3'h7, `VPT_RATE_40K_2);
        t_rate(1'b1, `VPT_RATE_64K, `VPT_RATE_64K);
    endtask
    task t_path;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i) loopback_select_i <= i[1:0];
            cyc(3);
            chk(loopback_o, i == 3 ? 2'h2 : i[1:0]);
        end
        @(posedge clock_i) {test_pattern_select_i, balance_set_i} <= {`VPT_PAT_QUIET, 3'h5};
        cyc(4);
        chk(line_terminate_o, 1'b1);
        chk(pcm_user_side_injection_o, `VPT_PCM_QUIET);
        chk(balance_pattern_o, `VPT_BAL_FIRST_BALANCE_SET);
        @(posedge clock_i) test_pattern_select_i <= `VPT_PAT_NONE;
        cyc(4);
        chk(line_terminate_o, 1'b0);
        chk(pcm_user_side_injection_o, 8'h5A);
        @(posedge clock_i) {user_side_injection_i, network_side_injection_i} <= 6'h24;
        cyc(4);
        chk(pcm_user_side_injection_o, `VPT_PCM_QUIET);
        chk(pcm_to_network_o, `VPT_PCM_QUIET);
        for (int c = 1; c < 4; c++) begin
            @(posedge clock_i) network_side_injection_i <= c[2:0];
            cyc(3);
            chk(pcm_to_network_o[6:0], 7'h3F);
        end
        @(posedge clock_i) cross_connect_i <= 1'b0;
        cyc(4);
        chk(pcm_user_side_injection_o, 8'h5A);
        chk(pcm_to_network_o, 8'hC3);
        @(posedge clock_i) {user_side_injection_i, network_side_injection_i} <= 6'h00;
    endtask
    task t_milliwatt;
        int n;
        logic [7:0] v;
        @(posedge clock_i) {port_selected_i, test_pattern_select_i} <= {1'b0, `VPT_PAT_MILLIWATT};
        cyc(4);
        chk(pcm_user_side_injection_o, 8'h5A);
        @(posedge clock_i) port_selected_i <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            v = pcm_user_side_injection_o;
            for (n = 0; n < 30000 && pcm_user_side_injection_o === v; n++) @(negedge clock_i);
        end
        chk(n[23:0], 24'h0061A8);
        chk(v[6:0], 7'h3F);
        @(posedge clock_i) receive_level_adjust_i <= 5'h04;
        cyc(3);
        chk(pcm_user_side_injection_o[6:0], 7'h43);
        @(posedge clock_i) test_pattern_select_i <= `VPT_PAT_NONE;
    endtask
    task burst_run(input logic [9:0] k, input logic exp);
        @(posedge clock_i) {burst, start} <= {k, 1'b1};
        @(posedge clock_i) start <= 1'b0;
        cyc(1);
        for (int n = 0; n < 1000 && far_busy === 1'b1; n++) @(negedge clock_i);
        cyc(6);
        chk(sig_alarm_o, exp);
    endtask
    task t_monitor;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i) monitor_toggle_i <= 1'b1;
            @(posedge clock_i) monitor_toggle_i <= 1'b0;
            cyc(2);
            chk(monitor_on_o, !i[0]);
            if (i == 0) burst_run(10'h0FF, 1'b0);
            if (i == 0) burst_run(10'h384, 1'b1);
            chk(receive_signaling_bits_o, receive_signaling_bits_i);
        end
        cyc(3);
        chk(sig_alarm_o, 1'b0);
    endtask
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(negedge clock_i);
        chk(pcm_user_side_injection_o, 8'hFF);
        chk(rate_o, `VPT_RATE_64K);
        chk(monitor_on_o, 1'b0);
        @(posedge clock_i) rst_n_i <= 1'b1;
        t_status;
        t_cga_busy;
        t_cga_call;
        t_rates;
        t_path;
        t_milliwatt;
        t_monitor;
        tally_and_finish;
    end
endmodule // vpt_port_tb
